// ==== design/lipm_regs.vh ====
// register offsets, field layout and reset values of the link interrupt and priority map block
// assumes an 8-bit register port addressed by the printed register offsets
`ifndef LIPM_REGS_VH
`define LIPM_REGS_VH
`define LIPM_ADDR_W 8
`define LIPM_OFS_STATUS 8'h7C
`define LIPM_OFS_MASK 8'h7D
`define LIPM_OFS_MAP_LOW 8'h80
`define LIPM_OFS_MAP_HIGH 8'h81
`define LIPM_PORTS 5
`define LIPM_PORT_MSB 4
`define LIPM_STATUS_RST 5'h00
`define LIPM_MASK_RST 5'h00
`define LIPM_MAP_LOW_RST 8'h50
`define LIPM_MAP_HIGH_RST 8'hFA
`define LIPM_READ_ZERO 8'h00
`define LIPM_HIGH_SEL_BIT 2
`define LIPM_PAIR_W 2
`define LIPM_NO_PORTS 5'h00
`define LIPM_LINK_RST 5'h00
`define LIPM_RSVD_ZERO 3'h0
`define LIPM_PRIO_RST 2'h0
`define LIPM_BIT_CLR 1'b0
`define LIPM_BIT_SET 1'b1
`endif

// ==== design/lipm_prio_lookup.v ====
// tag-to-priority lookup: picks the 2-bit field of the selected mapping register
// assumes map registers are held by the parent and tag is stable with its strobe
`timescale 1ns/1ps
`default_nettype none
`include "lipm_regs.vh"
module lipm_prio_lookup (
  // mapping registers
  input wire [7:0] map_low,
  input wire [7:0] map_high,
  // received frame tag
  input wire [2:0] pcp,
  // selected internal priority
  output reg [1:0] prio
);
  // returns the 2-bit field of a mapping byte chosen by the low tag bits
  function [1:0] pick_pair;
    input [7:0] map_byte;
    input [1:0] slot;
    begin
      pick_pair = map_byte[{slot, 1'b0} +: `LIPM_PAIR_W];
    end
  endfunction

  // tag bit 2 picks the register, low bits pick the pair
  always @* begin
    if (pcp[`LIPM_HIGH_SEL_BIT]) begin
      prio = pick_pair(map_high, pcp[1:0]);
    end else begin
      prio = pick_pair(map_low, pcp[1:0]);
    end
  end
endmodule
`default_nettype wire

// ==== design/lipm_top.v ====
// link-change interrupt status/mask and 802.1p priority map registers
// assumes synchronous 8-bit register port and per-port link state inputs on clk
`timescale 1ns/1ps
`default_nettype none
`include "lipm_regs.vh"
module lipm_top (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // per-port link state, bit 0 is port 1
  input wire [4:0] link_up,
  // received frame priority lookup
  input wire frame_valid,
  input wire [2:0] frame_pcp,
  output reg frame_prio_valid,
  output reg [1:0] frame_prio,
  // interrupt request
  output wire irq
);
  // port status, mask and previous link sample
  reg [4:0] status_q;
  reg [4:0] status_d;
  reg [4:0] mask_q;
  reg [4:0] mask_d;
  reg [4:0] link_q;
  reg link_init_q;
  // tag mapping registers
  reg [7:0] map_low_q;
  reg [7:0] map_low_d;
  reg [7:0] map_high_q;
  reg [7:0] map_high_d;
  // next values of the registered outputs
  reg [7:0] rdata_d;
  reg frame_prio_valid_d;
  reg [1:0] frame_prio_d;
  // decoded events and register strobes
  wire [4:0] link_change;
  wire [1:0] lookup_prio;
  wire wr_status;
  wire wr_mask;
  wire wr_map_low;
  wire wr_map_high;
  wire sel_status;
  wire sel_mask;
  wire sel_map_low;
  wire sel_map_high;

  // true when a strobe is high and the offset matches one register
  function offset_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
      offset_hit = strobe && (addr == offset);
    end
  endfunction

  // widens a per-port field to a byte; reserved bits 7:5 read zero
  function [7:0] port_byte;
    input [4:0] bits;
    begin
      port_byte = {`LIPM_RSVD_ZERO, bits};
    end
  endfunction

  // write-one-to-clear update; a set in the same cycle beats the clear
  function [4:0] w1c_update;
    input [4:0] cur;
    input [4:0] clr;
    input [4:0] set_bits;
    begin
      w1c_update = (cur & ~clr) | set_bits;
    end
  endfunction

  // write strobes, one per register; other offsets are ignored
  assign wr_status = offset_hit(reg_wr, reg_addr, `LIPM_OFS_STATUS);
  assign wr_mask = offset_hit(reg_wr, reg_addr, `LIPM_OFS_MASK);
  assign wr_map_low = offset_hit(reg_wr, reg_addr, `LIPM_OFS_MAP_LOW);
  assign wr_map_high = offset_hit(reg_wr, reg_addr, `LIPM_OFS_MAP_HIGH);

  // read selects; a read of any other offset returns zero
  assign sel_status = offset_hit(reg_rd, reg_addr, `LIPM_OFS_STATUS);
  assign sel_mask = offset_hit(reg_rd, reg_addr, `LIPM_OFS_MASK);
  assign sel_map_low = offset_hit(reg_rd, reg_addr, `LIPM_OFS_MAP_LOW);
  assign sel_map_high = offset_hit(reg_rd, reg_addr, `LIPM_OFS_MAP_HIGH);

  // previous link state; the first sample after reset is only a baseline,
  // so a port whose link is already up at release raises no false event
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= `LIPM_LINK_RST;
      link_init_q <= `LIPM_BIT_CLR;
    end else begin
      link_q <= link_up;
      link_init_q <= `LIPM_BIT_SET;
    end
  end

  // any difference from the previous sample is a link change, up or down
  assign link_change = link_init_q ? (link_q ^ link_up) : `LIPM_NO_PORTS;

  // status next value: write-one clears, a link change in the same cycle wins
  // so that software never loses an event that raced with its clear
  always @* begin
    if (wr_status) begin
      status_d = w1c_update(status_q, reg_wdata[`LIPM_PORT_MSB:0], link_change);
    end else begin
      status_d = w1c_update(status_q, `LIPM_NO_PORTS, link_change);
    end
  end

  // status register, one bit per port, bit 0 for port 1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `LIPM_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // mask next value; only the five port bits are stored
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[`LIPM_PORT_MSB:0];
    end
  end

  // mask register; a set bit keeps its port off the interrupt line
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `LIPM_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // mapping next values; each byte holds four 2-bit priorities
  always @* begin
    map_low_d = map_low_q;
    map_high_d = map_high_q;
    if (wr_map_low) begin
      map_low_d = reg_wdata;
    end
    if (wr_map_high) begin
      map_high_d = reg_wdata;
    end
  end

  // mapping registers, tag 0 and tag 4 in the lowest bit pair
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_low_q <= `LIPM_MAP_LOW_RST;
      map_high_q <= `LIPM_MAP_HIGH_RST;
    end else begin
      map_low_q <= map_low_d;
      map_high_q <= map_high_d;
    end
  end

  // read data next value; holds between reads so software may sample late
  always @* begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      if (sel_status) begin
        rdata_d = port_byte(status_q);
      end else if (sel_mask) begin
        rdata_d = port_byte(mask_q);
      end else if (sel_map_low) begin
        rdata_d = map_low_q;
      end else if (sel_map_high) begin
        rdata_d = map_high_q;
      end else begin
        rdata_d = `LIPM_READ_ZERO;
      end
    end
  end

  // read data register; a read that meets a write sees the old value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `LIPM_READ_ZERO;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // tag to priority lookup against the current mapping registers
  lipm_prio_lookup u_lipm_prio_lookup (
    .map_low(map_low_q),
    .map_high(map_high_q),
    .pcp(frame_pcp),
    .prio(lookup_prio)
  );

  // lookup result is taken only with the strobe and held until the next one
  always @* begin
    frame_prio_valid_d = frame_valid;
    frame_prio_d = frame_prio;
    if (frame_valid) begin
      frame_prio_d = lookup_prio;
    end
  end

  // registered priority result, one cycle after the frame strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_prio_valid <= `LIPM_BIT_CLR;
      frame_prio <= `LIPM_PRIO_RST;
    end else begin
      frame_prio_valid <= frame_prio_valid_d;
      frame_prio <= frame_prio_d;
    end
  end

  // interrupt while any unmasked status bit is pending; a level, not a pulse,
  // so a shared line may be polled without losing a request
  assign irq = |(status_q & ~mask_q);
endmodule
`default_nettype wire

// ==== sim/lipm_chk_assertions.sv ====
// port-level checks of lipm_top
// bound into lipm_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module lipm_chk (
  // clock, reset and strobes
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic frame_valid,
  input wire logic frame_prio_valid,
  input wire logic irq,
  // buses
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] link_up,
  input wire logic [2:0] frame_pcp,
  input wire logic [1:0] frame_prio
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_lookup_pulse: assert property (frame_valid |=> frame_prio_valid)
    else $error("no lookup");
  a_low_pick: assert property ((reg_wr && reg_addr == 8'h80) ##1 (frame_valid && !frame_pcp[2])
    |=> frame_prio == (($past(reg_wdata, 2) >> 2 * ($past(frame_pcp) % 4)) & 3)) else $error("low");
  a_high_pick: assert property ((reg_wr && reg_addr == 8'h81) ##1 (frame_valid && frame_pcp[2])
    |=> frame_prio == (($past(reg_wdata, 2) >> 2 * ($past(frame_pcp) % 4)) & 3)) else $error("high");
  a_link_sets: assert property ($changed(link_up) ##1 (reg_rd && reg_addr == 8'h7C)
    |=> (reg_rdata ^ $past(link_up, 2) ^ $past(link_up, 3)) == 0) else $error("link");
  a_one_clears: assert property ((reg_wr && reg_addr == 8'h7C && $stable(link_up)) ##1
    (reg_rd && reg_addr == 8'h7C) |=> (reg_rdata & $past(reg_wdata, 2)) == 0) else $error("w1c");
  a_mask_rw: assert property ((reg_wr && reg_addr == 8'h7D) ##1 (reg_rd && reg_addr == 8'h7D)
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F)) else $error("mask");
  a_masked_quiet: assert property ((reg_wr && reg_addr == 8'h7D && reg_wdata == 8'h1F) |=> !irq)
    else $error("irq");
  c_irq: cover property ($rose(irq));
  c_link: cover property ($changed(link_up) ##1 reg_rd);
  c_prio: cover property (frame_prio_valid && frame_prio == 2'h3);
endmodule
bind lipm_top lipm_chk u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .frame_valid(frame_valid),
  .frame_prio_valid(frame_prio_valid),
  .irq(irq),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .link_up(link_up),
  .frame_pcp(frame_pcp),
  .frame_prio(frame_prio)
);
`default_nettype wire

// ==== sim/test_link_irq_and_priority_map.sv ====
// bench for lipm_top: maps, link status, mask
// needs the design and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_link_irq_and_priority_map;
  logic clk, rst_n, reg_wr, reg_rd, frame_valid, frame_prio_valid, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [4:0] link_up;
  logic [2:0] frame_pcp;
  logic [1:0] frame_prio;
  int err_count, cmp_count;
  // tag and priority under the reset maps
  logic [4:0] rows [8] = '{5'h00, 5'h04, 5'h09, 5'h0D, 5'h12, 5'h16, 5'h1B, 5'h1F};
  lipm_top u_lipm_top (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .link_up(link_up),
    .frame_valid(frame_valid),
    .frame_pcp(frame_pcp),
    .frame_prio_valid(frame_prio_valid),
    .frame_prio(frame_prio),
    .irq(irq)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rd", reg_rdata, e);
    @(posedge clk);
  endtask
  task frm(input logic [2:0] p, input logic [1:0] e);
    frame_pcp <= p;
    frame_valid <= 1'b1;
    @(posedge clk);
    frame_valid <= 1'b0;
    #1 chk("pv", frame_prio_valid, 1'b1);
    chk("pr", frame_prio, e);
    @(posedge clk);
  endtask
  task ck_irq(input logic e);
    #1 chk("irq", irq, e);
    @(posedge clk);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, frame_valid, reg_addr, reg_wdata, link_up, frame_pcp} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h7D, 8'h00);
    rd(8'h80, 8'h50);
    rd(8'h81, 8'hFA);
    foreach (rows[i]) frm(rows[i][4:2], rows[i][1:0]);
    wr(8'h80, 8'hE4);
    frm(3'h3, 2'h3);
    wr(8'h81, 8'h1B);
    frm(3'h4, 2'h3);
    link_up <= 5'h04;
    @(posedge clk);
    rd(8'h7C, 8'h04);
    wr(8'h7D, 8'h1F);
    rd(8'h7D, 8'h1F);
    ck_irq(1'b0);
    wr(8'h7D, 8'h00);
    ck_irq(1'b1);
    wr(8'h7C, 8'h1B);
    rd(8'h7C, 8'h04);
    wr(8'h7C, 8'h04);
    rd(8'h7C, 8'h00);
    ck_irq(1'b0);
    // link change in the same cycle as its clear: the set wins
    link_up <= 5'h00;
    @(posedge clk);
    link_up <= 5'h04;
    wr(8'h7C, 8'h04);
    rd(8'h7C, 8'h04);
    ck_irq(1'b1);
    // reset in mid-run with a link already up: no event from the baseline
    rst_n <= 1'b0;
    ck_irq(1'b0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h7C, 8'h00);
    rd(8'h80, 8'h50);
    rd(8'h81, 8'hFA);
    // reserved mask bits read zero, unmapped offsets ignored
    wr(8'h7D, 8'hFF);
    rd(8'h7D, 8'h1F);
    wr(8'h82, 8'hFF);
    rd(8'h82, 8'h00);
    rd(8'h81, 8'hFA);
    stop_test;
  end
  // watchdog, far beyond the 76 or so cycles needed
  initial begin
    #20us;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
